// ==== core/iefc_pkg.sv ====
// package of the interrupt enable and flag block: register map, field positions, reset values
// assumes an 8-bit register port with a 3-bit word address
package iefc_pkg;

  // register port geometry
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 3;

  // register word addresses
  localparam logic [2:0] ADDR_MAIN_CTRL = 3'h0;
  localparam logic [2:0] ADDR_PERIPH_EN = 3'h1;
  localparam logic [2:0] ADDR_PERIPH_FLAG = 3'h2;
  localparam logic [2:0] ADDR_EVT_STATUS = 3'h3;
  localparam logic [2:0] ADDR_EVT_MASK = 3'h4;

  // main control register fields
  localparam int unsigned MC_GLOBAL_EN = 7;
  localparam int unsigned MC_PERIPH_GRP_EN = 6;
  localparam int unsigned MC_TMR0_EN = 5;
  localparam int unsigned MC_EXT_EN = 4;
  localparam int unsigned MC_PORT_EN = 3;
  localparam int unsigned MC_TMR0_FLAG = 2;
  localparam int unsigned MC_EXT_FLAG = 1;
  localparam int unsigned MC_PORT_FLAG = 0;
  localparam int unsigned MC_FLAG_N = 3;

  // peripheral enable and flag fields share one layout
  localparam int unsigned PF_EEPROM = 7;
  localparam int unsigned PF_CMP = 6;
  localparam int unsigned PF_RX = 5;
  localparam int unsigned PF_TX = 4;
  localparam int unsigned PF_CCP = 2;
  localparam int unsigned PF_TMR2 = 1;
  localparam int unsigned PF_TMR1 = 0;
  // bit 3 is unimplemented; receive and transmit flags are read only
  localparam logic [7:0] PERIPH_IMPL_MASK = 8'hF7;
  localparam logic [7:0] PERIPH_FLAG_WR_MASK = 8'hC7;

  // event status and mask fields
  localparam int unsigned EV_TMR0 = 0;
  localparam int unsigned EV_EXT = 1;
  localparam int unsigned EV_PORT = 2;
  localparam int unsigned EV_PERIPH = 3;
  localparam int unsigned EV_CORE_REQ = 4;
  localparam int unsigned EV_N = 5;
  localparam logic [7:0] EV_IMPL_MASK = 8'h1F;

  // reset values
  localparam logic [7:0] MAIN_CTRL_RST = 8'h00;
  localparam logic [7:0] PERIPH_EN_RST = 8'h00;
  localparam logic [7:0] PERIPH_FLAG_RST = 8'h00;
  localparam logic [7:0] EVT_MASK_RST = 8'h00;

  // width of the port-change pin group
  localparam int unsigned PORT_W = 4;

endpackage

// ==== core/iefc_sync.sv ====
// two-flop synchroniser for a group of pin levels
// assumes the pins are asynchronous to i_mclk; each bit is crossed on its own
`timescale 1ns/1ps
module iefc_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // raw pins and synchronised copy
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage is read only by the second stage
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule // iefc_sync

// ==== core/iefc_flag_bit.sv ====
// bank of sticky flags: a set term and a clear term per bit
// assumes the parent builds both terms; a set in the clear cycle wins
`timescale 1ns/1ps
module iefc_flag_bit #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // per-bit set and clear terms
  input wire logic [W-1:0] i_set,
  input wire logic [W-1:0] i_clr,
  // flag state
  output logic [W-1:0] o_flag
);

  logic [W-1:0] flag_q;
  logic [W-1:0] flag_d;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // set over clear, so an event in the clearing cycle is kept
      assign flag_d[g] = i_set[g] | (flag_q[g] & ~i_clr[g]);
    end
  endgenerate

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign o_flag = flag_q;

endmodule // iefc_flag_bit

// ==== core/iefc_top.sv ====
// interrupt enable and flag block of an 8-bit controller core
// assumes peripheral event pulses on i_mclk, pins raw, and a one-cycle register port
// Contract
// - main control register is fully readable and writable by software.
// - main control holds global and group enables plus enables and flags for timer0, external and port-change sources.
// - a flag sets on its source event whatever its enable bit says.
// - global enable sits at main control bit 7 and never blocks flag setting.
// - peripheral enable register holds the seven peripheral source enables only.
// - peripheral flag register holds the flags matching those enables.
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module iefc_top (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // register port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // main source events, same clock
  input wire logic i_tmr0_ovf,
  input wire logic i_edge_rising_sel,
  // main source pins, asynchronous
  input wire logic i_ext_pin,
  input wire logic [3:0] i_port_pins,
  // peripheral source events, same clock
  input wire logic i_eeprom_done,
  input wire logic i_cmp_change,
  input wire logic i_rx_ready,
  input wire logic i_tx_ready,
  input wire logic i_ccp_event,
  input wire logic i_tmr2_match,
  input wire logic i_tmr1_ovf,
  // requests
  output logic o_core_irq,
  output logic o_irq
);

  // decode
  // address decoding, used for both read and write paths
  function automatic logic hit(input logic [2:0] a, input logic [2:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  wire wr_main = i_wr && hit(i_addr, iefc_pkg::ADDR_MAIN_CTRL);
  wire wr_pen = i_wr && hit(i_addr, iefc_pkg::ADDR_PERIPH_EN);
  wire wr_pflag = i_wr && hit(i_addr, iefc_pkg::ADDR_PERIPH_FLAG);
  wire wr_status = i_wr && hit(i_addr, iefc_pkg::ADDR_EVT_STATUS);
  wire wr_mask = i_wr && hit(i_addr, iefc_pkg::ADDR_EVT_MASK);

  // pins
  logic ext_s;
  logic [3:0] port_s;
  logic ext_prev_q;
  logic [3:0] port_prev_q;

  // pins are crossed before any edge or change detection looks at them
  iefc_sync #(.W(1)) u_ext_sync (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_async(i_ext_pin),
    .o_sync(ext_s)
  );

  iefc_sync #(.W(iefc_pkg::PORT_W)) u_port_sync (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_async(i_port_pins),
    .o_sync(port_s)
  );

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ext_prev_q <= 1'b0;
      port_prev_q <= 4'h0;
    end else begin
      ext_prev_q <= ext_s;
      port_prev_q <= port_s;
    end
  end

  // edge polarity is picked by the option logic outside this block
  wire ext_rise = ext_s && !ext_prev_q;
  wire ext_fall = !ext_s && ext_prev_q;
  wire ext_evt = i_edge_rising_sel ? ext_rise : ext_fall;
  wire port_evt = |(port_s ^ port_prev_q);

  // main control
  logic [4:0] main_en_q;
  logic [2:0] main_flag;
  wire [2:0] main_evt = {i_tmr0_ovf, ext_evt, port_evt};

  // enable half of main control, plain read/write storage
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      main_en_q <= iefc_pkg::MAIN_CTRL_RST[7:3];
    end else if (wr_main) begin
      main_en_q <= i_wdata[7:3];
    end
  end

  // flag half: events set regardless of any enable, software writes either value
  wire [2:0] main_flag_set = main_evt | ({3{wr_main}} & i_wdata[2:0]);
  wire [2:0] main_flag_clr = {3{wr_main}} & ~i_wdata[2:0];

  iefc_flag_bit #(.W(iefc_pkg::MC_FLAG_N)) u_main_flags (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_set(main_flag_set),
    .i_clr(main_flag_clr),
    .o_flag(main_flag)
  );

  // comparator is absent here; it lives in the peripheral pair
  wire [7:0] main_ctrl = {main_en_q, main_flag};
  wire global_en = main_ctrl[iefc_pkg::MC_GLOBAL_EN];
  wire grp_en = main_ctrl[iefc_pkg::MC_PERIPH_GRP_EN];

  // peripheral pair
  logic [7:0] pen_q;
  logic [7:0] pflag_rw;
  logic rx_flag_q;
  logic tx_flag_q;

  // enable register keeps only the implemented bits
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      pen_q <= iefc_pkg::PERIPH_EN_RST;
    end else if (wr_pen) begin
      pen_q <= i_wdata & iefc_pkg::PERIPH_IMPL_MASK;
    end
  end

  // writable flags: eeprom, comparator, capture/compare, timer2, timer1
  wire [7:0] pevt = {i_eeprom_done, i_cmp_change, 2'b00, 1'b0,
                     i_ccp_event, i_tmr2_match, i_tmr1_ovf};
  wire [7:0] pwr_bits = {8{wr_pflag}} & iefc_pkg::PERIPH_FLAG_WR_MASK;
  wire [7:0] pflag_set = pevt | (pwr_bits & i_wdata);
  wire [7:0] pflag_clr = pwr_bits & ~i_wdata;

  iefc_flag_bit #(.W(8)) u_periph_flags (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_set(pflag_set),
    .i_clr(pflag_clr),
    .o_flag(pflag_rw)
  );

  // receive and transmit flags follow their source, software cannot write them
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_flag_q <= 1'b0;
      tx_flag_q <= 1'b0;
    end else begin
      rx_flag_q <= i_rx_ready;
      tx_flag_q <= i_tx_ready;
    end
  end

  wire [7:0] pflag = {pflag_rw[7:6], rx_flag_q, tx_flag_q, 1'b0, pflag_rw[2:0]};

  // core request
  logic core_irq_q;
  wire main_hit = |(main_en_q[2:0] & main_flag);
  wire periph_hit = grp_en && |(pen_q & pflag);
  wire core_irq_d = global_en && (main_hit || periph_hit);

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      core_irq_q <= 1'b0;
    end else begin
      core_irq_q <= core_irq_d;
    end
  end

  assign o_core_irq = core_irq_q;

  // event status
  logic [4:0] ev_status;
  logic [4:0] ev_mask_q;
  // the peripheral bit marks any peripheral source pulse or a rise of receive or transmit ready
  wire periph_evt = |pevt || (i_rx_ready && !rx_flag_q) || (i_tx_ready && !tx_flag_q);
  wire core_rise = core_irq_d && !core_irq_q;
  wire [4:0] ev_set = {core_rise, periph_evt, main_evt[0], main_evt[1], main_evt[2]};
  wire [4:0] ev_clr = {5{wr_status}} & i_wdata[4:0];

  iefc_flag_bit #(.W(iefc_pkg::EV_N)) u_ev_status (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_set(ev_set),
    .i_clr(ev_clr),
    .o_flag(ev_status)
  );

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ev_mask_q <= iefc_pkg::EVT_MASK_RST[4:0];
    end else if (wr_mask) begin
      ev_mask_q <= i_wdata[4:0];
    end
  end

  // level output: stays high until every unmasked status bit is cleared
  assign o_irq = |(ev_status & ev_mask_q);

  // read path
  logic [7:0] rdata_q;
  wire [7:0] rd_mux =
    hit(i_addr, iefc_pkg::ADDR_MAIN_CTRL) ? main_ctrl :
    hit(i_addr, iefc_pkg::ADDR_PERIPH_EN) ? pen_q :
    hit(i_addr, iefc_pkg::ADDR_PERIPH_FLAG) ? pflag :
    hit(i_addr, iefc_pkg::ADDR_EVT_STATUS) ? {3'h0, ev_status} :
    hit(i_addr, iefc_pkg::ADDR_EVT_MASK) ? {3'h0, ev_mask_q} :
    8'h00; // unmapped addresses read as zero

  // data stands only in the cycle after the read strobe
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= i_rd ? rd_mux : 8'h00;
    end
  end

  assign o_rdata = rdata_q;

  // assertions
  sequence s_main_write;
    wr_main;
  endsequence

  sequence s_main_read;
    i_rd && hit(i_addr, iefc_pkg::ADDR_MAIN_CTRL) && !i_wr;
  endsequence

  a_main_rw_enables: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    s_main_write |=> main_en_q == $past(i_wdata[7:3]))
    else $error("main control enables did not take the written value");

  a_main_read_back: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    s_main_read |=> o_rdata == $past(main_ctrl))
    else $error("main control read data wrong");

  a_flag_set_any: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    i_tmr0_ovf |=> main_flag[2])
    else $error("timer0 flag not set by its event");

  a_flag_gie_off: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    (!global_en && i_tmr1_ovf) |=> pflag[iefc_pkg::PF_TMR1])
    else $error("flag blocked while global enable clear");

  a_flag_set_wins: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    (i_eeprom_done && wr_pflag && !i_wdata[7]) |=> pflag[iefc_pkg::PF_EEPROM])
    else $error("event lost in clearing cycle");

  a_pen_unimpl_zero: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    pen_q[3] == 1'b0 && pflag[3] == 1'b0)
    else $error("unimplemented peripheral bit is set");

  a_rx_readonly: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    (wr_pflag && !i_rx_ready) |=> !pflag[iefc_pkg::PF_RX])
    else $error("receive flag was written by software");

  a_core_req_group: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    (!grp_en && main_en_q[2:0] == 3'h0) |=> !o_core_irq)
    else $error("peripheral request without group enable");

  a_core_req_track: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    ##1 o_core_irq == $past(global_en && (main_hit || periph_hit)))
    else $error("core request does not follow enables and flags");

  a_irq_level: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    (ev_status[0] && ev_mask_q[0] && !wr_status && !wr_mask) [*2] |-> o_irq)
    else $error("interrupt output dropped with unmasked status set");

  // edges seen on the synchronised pin, judged apart from the detector flops
  sequence s_ext_rise_seen;
    i_edge_rising_sel && $rose(ext_s);
  endsequence

  sequence s_ext_fall_seen;
    !i_edge_rising_sel && $fell(ext_s);
  endsequence

  a_ext_rise_flag: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    s_ext_rise_seen |=> main_flag[iefc_pkg::MC_EXT_FLAG])
    else $error("external flag missed a rising edge");

  a_ext_fall_flag: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    s_ext_fall_seen |=> main_flag[iefc_pkg::MC_EXT_FLAG])
    else $error("external flag missed a falling edge");

  a_rx_flag_follow: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    1'b1 |=> pflag[iefc_pkg::PF_RX] == $past(i_rx_ready))
    else $error("receive flag does not follow its source");

  a_rdata_idle_zero: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data not zero outside a read");

  a_status_w1c_clear: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    (wr_status && i_wdata[iefc_pkg::EV_CORE_REQ] && !core_rise)
      |=> !ev_status[iefc_pkg::EV_CORE_REQ])
    else $error("status bit not cleared by writing one");

endmodule // iefc_top

// ==== bench/iefc_src_model.sv ====
// model of the event sources and pins around the interrupt block
// assumes one clock and that the bench calls its tasks from a single process
`timescale 1ns/1ps
module iefc_src_model (
  // clock
  input wire logic i_mclk,
  // same-clock pulses {eeprom,cmp,-,-,tmr0,ccp,tmr2,tmr1}
  output logic [7:0] o_pulse,
  // receive and transmit ready levels
  output logic o_rx_ready,
  output logic o_tx_ready,
  // raw pins, asynchronous to the block
  output logic o_ext_pin,
  output logic [3:0] o_port_pins
);
  // everything quiet at time zero so no stray event appears after reset
  initial begin
    o_pulse = 8'h00;
    o_rx_ready = 1'b0;
    o_tx_ready = 1'b0;
    o_ext_pin = 1'b0;
    o_port_pins = 4'h0;
  end

  // one-cycle pulses: launched after an edge, taken by the block at the next one
  task automatic fire(input logic [7:0] m);
    @(posedge i_mclk);
    o_pulse <= m;
    @(posedge i_mclk);
    o_pulse <= 8'h00;
  endtask

  // levels and pins change together after an edge
  task automatic levels(input logic rx, input logic tx, input logic ext, input logic [3:0] pp);
    @(posedge i_mclk);
    o_rx_ready <= rx;
    o_tx_ready <= tx;
    o_ext_pin <= ext;
    o_port_pins <= pp;
  endtask
endmodule // iefc_src_model

// ==== bench/interrupt_enable_flag_control_tb.sv ====
// self-checking bench of the interrupt enable and flag block
// assumes the source model drives all event inputs; the bench is the register master
`timescale 1ns/1ps
module interrupt_enable_flag_control_tb;
  logic i_mclk;
  logic i_resetn;
  logic [2:0] i_addr;
  logic [7:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic i_edge_rising_sel;
  logic [7:0] o_rdata;
  logic o_core_irq;
  logic o_irq;
  logic [7:0] src_pulse;
  logic src_rx;
  logic src_tx;
  logic src_ext;
  logic [3:0] src_port;
  int bad_count;
  int n_tests;

  iefc_top dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tmr0_ovf(src_pulse[3]),
    .i_edge_rising_sel(i_edge_rising_sel), .i_ext_pin(src_ext), .i_port_pins(src_port),
    .i_eeprom_done(src_pulse[7]), .i_cmp_change(src_pulse[6]), .i_rx_ready(src_rx),
    .i_tx_ready(src_tx), .i_ccp_event(src_pulse[2]), .i_tmr2_match(src_pulse[1]),
    .i_tmr1_ovf(src_pulse[0]), .o_core_irq(o_core_irq), .o_irq(o_irq));

  iefc_src_model src (.i_mclk(i_mclk), .o_pulse(src_pulse), .o_rx_ready(src_rx),
    .o_tx_ready(src_tx), .o_ext_pin(src_ext), .o_port_pins(src_port));

  // clock at 100 MHz
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask

  // bounded wait for a request output: sel 1 watches o_core_irq, 0 watches o_irq
  task automatic wait_out(input logic sel, input logic exp);
    logic v;
    v = ~exp;
    for (int i = 0; i < 5 && v !== exp; i++) begin
      @(posedge i_mclk);
      #1;
      v = sel ? o_core_irq : o_irq;
    end
    chk({7'h00, v}, {7'h00, exp});
    // a used-up bound ends the run through the closing report
    if (v !== exp) test_done();
  endtask

  task automatic t_reset;
    for (int a = 0; a < 6; a++) rd(a[2:0], 8'h00);
  endtask

  task automatic t_main_rw;
    logic [7:0] pat [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
    foreach (pat[i]) begin
      wr(iefc_pkg::ADDR_MAIN_CTRL, pat[i]);
      rd(iefc_pkg::ADDR_MAIN_CTRL, pat[i]);
    end
  endtask

  task automatic t_periph_en;
    wr(iefc_pkg::ADDR_PERIPH_EN, 8'hFF);
    rd(iefc_pkg::ADDR_PERIPH_EN, 8'hF7);
    wr(iefc_pkg::ADDR_PERIPH_EN, 8'h00);
    rd(iefc_pkg::ADDR_PERIPH_EN, 8'h00);
  endtask

  // every same-clock source fires with only global enable on; global enable on must not matter
  task automatic t_flags;
    wr(iefc_pkg::ADDR_EVT_STATUS, 8'hFF);
    wr(iefc_pkg::ADDR_MAIN_CTRL, 8'h80);
    src.fire(8'hCF);
    rd(iefc_pkg::ADDR_MAIN_CTRL, 8'h84);
    rd(iefc_pkg::ADDR_PERIPH_FLAG, 8'hC7);
    rd(iefc_pkg::ADDR_EVT_STATUS, 8'h09);
    chk({7'h00, o_core_irq}, 8'h00);
    src.levels(1'b1, 1'b1, 1'b0, 4'h0);
    rd(iefc_pkg::ADDR_PERIPH_FLAG, 8'hF7);
    src.levels(1'b0, 1'b0, 1'b0, 4'h0);
    wr(iefc_pkg::ADDR_PERIPH_FLAG, 8'h00);
    wr(iefc_pkg::ADDR_MAIN_CTRL, 8'h00);
    rd(iefc_pkg::ADDR_PERIPH_FLAG, 8'h00);
    // an event in the same cycle as a clearing write must survive
    fork
      src.fire(8'h80);
      wr(iefc_pkg::ADDR_PERIPH_FLAG, 8'h00);
    join
    rd(iefc_pkg::ADDR_PERIPH_FLAG, 8'h80);
    // receive and transmit flags ignore a write of ones
    wr(iefc_pkg::ADDR_PERIPH_FLAG, 8'hFF);
    rd(iefc_pkg::ADDR_PERIPH_FLAG, 8'hC7);
    wr(iefc_pkg::ADDR_PERIPH_FLAG, 8'h00);
  endtask

  task automatic t_core_req;
    wr(iefc_pkg::ADDR_PERIPH_FLAG, 8'h00);
    wr(iefc_pkg::ADDR_PERIPH_EN, 8'h01);
    wr(iefc_pkg::ADDR_MAIN_CTRL, 8'h80);
    src.fire(8'h01);
    repeat (3) @(posedge i_mclk);
    chk({7'h00, o_core_irq}, 8'h00);
    wr(iefc_pkg::ADDR_MAIN_CTRL, 8'hC0);
    wait_out(1'b1, 1'b1);
    wr(iefc_pkg::ADDR_PERIPH_FLAG, 8'h00);
    wait_out(1'b1, 1'b0);
    wr(iefc_pkg::ADDR_MAIN_CTRL, 8'hA0);
    src.fire(8'h08);
    wait_out(1'b1, 1'b1);
    wr(iefc_pkg::ADDR_MAIN_CTRL, 8'h20);
    wait_out(1'b1, 1'b0);
    wr(iefc_pkg::ADDR_MAIN_CTRL, 8'h00);
    wr(iefc_pkg::ADDR_PERIPH_EN, 8'h00);
    // status keeps core rise, peripheral and timer0 events of this scenario
    rd(iefc_pkg::ADDR_EVT_STATUS, 8'h19);
  endtask

  // pins cross a synchroniser, so allow a few cycles before reading back
  task automatic t_pins;
    src.levels(1'b0, 1'b0, 1'b1, 4'h0);
    repeat (6) @(posedge i_mclk);
    rd(iefc_pkg::ADDR_MAIN_CTRL, 8'h02);
    src.levels(1'b0, 1'b0, 1'b1, 4'h5);
    repeat (6) @(posedge i_mclk);
    rd(iefc_pkg::ADDR_MAIN_CTRL, 8'h03);
    wr(iefc_pkg::ADDR_MAIN_CTRL, 8'h00);
    i_edge_rising_sel <= 1'b0;
    src.levels(1'b0, 1'b0, 1'b0, 4'h5);
    repeat (6) @(posedge i_mclk);
    rd(iefc_pkg::ADDR_MAIN_CTRL, 8'h02);
    wr(iefc_pkg::ADDR_MAIN_CTRL, 8'h00);
  endtask

  // sticky status, mask and the level output
  task automatic t_status_irq;
    // timer0 events land in status bit 0
    wr(iefc_pkg::ADDR_EVT_STATUS, 8'hFF);
    wr(iefc_pkg::ADDR_EVT_MASK, 8'h01);
    rd(iefc_pkg::ADDR_EVT_MASK, 8'h01);
    src.fire(8'h08);
    wait_out(1'b0, 1'b1);
    wr(iefc_pkg::ADDR_EVT_MASK, 8'h00);
    wait_out(1'b0, 1'b0);
    wr(iefc_pkg::ADDR_EVT_MASK, 8'h01);
    wait_out(1'b0, 1'b1);
    wr(iefc_pkg::ADDR_EVT_STATUS, 8'h01);
    wait_out(1'b0, 1'b0);
    wr(iefc_pkg::ADDR_MAIN_CTRL, 8'h00);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    bad_count = 0;
    n_tests = 0;
    i_resetn = 1'b0;
    i_addr = 3'h0;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_edge_rising_sel = 1'b1;
    repeat (5) @(posedge i_mclk);
    i_resetn <= 1'b1;
    t_reset();
    t_main_rw();
    t_periph_en();
    t_flags();
    t_core_req();
    t_pins();
    t_status_irq();
    test_done();
  end

  // a hang counts as a mismatch
  initial begin
    #200000;
    bad_count++;
    test_done();
  end
endmodule // interrupt_enable_flag_control_tb
